// File: hdl/fdp_pkg.sv
// constants and types shared by the converter data port
package fdp_pkg;

   // ------------------------------------------------------------------
   // widths and sizes
   // ------------------------------------------------------------------
   localparam int BUS_W      = 10;
   localparam int FIFO_DEPTH = 32;
   localparam int DIV_W      = 8;

   // ------------------------------------------------------------------
   // timing
   // ------------------------------------------------------------------
   localparam int MCLK_PERIOD_PS = 25000;
   localparam int TURN_GAP_NS    = 50;
   // least time, rounded up to whole cycles
   localparam int TURN_GAP_CYC   =
      (TURN_GAP_NS * 1000 + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS;
   localparam logic [DIV_W-1:0] TX_HALF_DIV_DEF = 8'h02;
   localparam logic [DIV_W-1:0] RX_HALF_DIV_DEF = 8'h02;

   // ------------------------------------------------------------------
   // interpolation codes
   // ------------------------------------------------------------------
   localparam logic [1:0] INTERP_1X = 2'h0;
   localparam logic [1:0] INTERP_2X = 2'h1;
   localparam logic [1:0] INTERP_4X = 2'h2;

   // ------------------------------------------------------------------
   // positions in the synchronised pin vector
   // ------------------------------------------------------------------
   localparam int P_LOWER  = 0;
   localparam int P_UPPER  = 10;
   localparam int P_TXPD   = 20;
   localparam int P_RXPD   = 21;
   localparam int P_ADCDIV = 22;
   localparam int P_INTERP = 24;
   localparam int P_COMPAT = 26;
   localparam int P_FD     = 27;
   localparam int P_WIDTH  = 28;
   localparam int P_ONE    = 29;
   localparam int PIN_W    = 30;

   // ------------------------------------------------------------------
   // modes and states
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_FULL_DUPLEX   = 2'h0,
      MODE_HD_INTERLEAVE = 2'h1,
      MODE_HD_PARALLEL   = 2'h2,
      MODE_COMPAT        = 2'h3
   } mode_e;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_RX   = 4'h2,
      ST_TX   = 4'h4,
      ST_TURN = 4'h8
   } state_e;

endpackage : fdp_pkg

// File: hdl/flexible_converter_data_port.sv
// flexible converter data port: bus multiplexer, link clocks, receive fifo
//
// Overview of operation
// - full duplex: upper takes tx, lower drives rx
// - full duplex needs 2x or 4x interpolation
// - tx marker high is channel A, low B
// - full duplex: pin three carries tx clock
// - interleaved rx: two words per sample, alternating
// - rx indicator low for A, high for B
// - programmable divider on the adc clock
// - hd interleaved: selector tri-states the idle bus
// - hd interleaved: idle bus msb is marker
// - hd interleaved: tx on upper, rx on lower
// - half duplex: pin three follows active path
// - hd interleaved needs 2x or 4x interpolation
// - hd parallel: both buses turn together
// - hd parallel allows 1x, 2x and 4x
// - hd parallel tx: A upper, B lower
// - parallel rx: A lower, B upper
// - compat mode only by register, 2x/4x
// - compat: parallel rx, interleaved tx
// - compat rx: one word pair per clock
// - full duplex: independent rx/tx power down
// - mode inputs captured at reset release
// - width strap low parallel, high interleaved

// ----------------------------------------------------------------------
// receive fifo
// ----------------------------------------------------------------------
module fdp_fifo #(
   parameter int WIDTH = 20,
   parameter int DEPTH = 32
) (
   input  wire logic             i_clk,
   input  wire logic             i_rst,
   input  wire logic [WIDTH-1:0] i_in_data,
   input  wire logic             i_in_valid,
   output logic                  o_in_ready,
   output logic      [WIDTH-1:0] o_out_data,
   output logic                  o_out_valid,
   input  wire logic             i_out_ready
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW:0] wr_ptr;
      logic [AW:0] rd_ptr;
   } fifo_s;

   fifo_s            r;
   fifo_s            next_r;
   logic [WIDTH-1:0] mem [DEPTH];
   logic             full;
   logic             empty;
   logic             push;
   logic             pop;

   assign empty       = (r.wr_ptr == r.rd_ptr);
   assign full        = (r.wr_ptr[AW-1:0] == r.rd_ptr[AW-1:0]) &&
                        (r.wr_ptr[AW] != r.rd_ptr[AW]);
   assign o_in_ready  = !full;
   assign o_out_valid = !empty;
   assign o_out_data  = mem[r.rd_ptr[AW-1:0]];
   assign push        = i_in_valid && !full;
   assign pop         = i_out_ready && !empty;

   always_comb begin
      next_r = r;
      if (push) begin
         next_r.wr_ptr = r.wr_ptr + 1'b1;
      end
      if (pop) begin
         next_r.rd_ptr = r.rd_ptr + 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
      if (push) begin
         mem[r.wr_ptr[AW-1:0]] <= i_in_data;
      end
   end
endmodule // fdp_fifo

// ----------------------------------------------------------------------
// data port top
// ----------------------------------------------------------------------
module flexible_converter_data_port
   import fdp_pkg::*;
#(
   parameter logic [DIV_W-1:0] TX_HALF_DIV = TX_HALF_DIV_DEF,
   parameter logic [DIV_W-1:0] RX_HALF_DIV = RX_HALF_DIV_DEF
) (
   input  wire logic             I_MCLK,
   input  wire logic             I_SYS_RST,
   input  wire logic             I_IFACE_PIN_ONE,
   input  wire logic             I_IFACE_PIN_TWO,
   output logic                  O_IFACE_PIN_TWO,
   output logic                  O_IFACE_PIN_TWO_OE_N,
   output logic                  O_IFACE_PIN_THREE,
   input  wire logic [BUS_W-1:0] I_UPPER_BUS,
   output logic      [BUS_W-1:0] O_UPPER_BUS,
   output logic      [BUS_W-1:0] O_UPPER_BUS_OE_N,
   input  wire logic [BUS_W-1:0] I_LOWER_BUS,
   output logic      [BUS_W-1:0] O_LOWER_BUS,
   output logic      [BUS_W-1:0] O_LOWER_BUS_OE_N,
   input  wire logic             I_FULL_DUPLEX_MODE,
   input  wire logic             I_COMPAT_MODE_SEL,
   input  wire logic [1:0]       I_INTERP_SEL,
   input  wire logic [1:0]       I_ADC_CLK_DIV,
   input  wire logic             I_RECEIVE_POWER_DOWN,
   input  wire logic             I_TRANSMIT_POWER_DOWN,
   input  wire logic [BUS_W-1:0] I_RX_A_DATA,
   input  wire logic [BUS_W-1:0] I_RX_B_DATA,
   input  wire logic             I_RX_VALID,
   output logic                  O_RX_READY,
   output logic      [BUS_W-1:0] O_TX_A_DATA,
   output logic      [BUS_W-1:0] O_TX_B_DATA,
   output logic                  O_TX_VALID,
   output logic      [1:0]       O_MODE,
   output logic      [1:0]       O_INTERP,
   output logic                  O_CFG_ERROR,
   output logic                  O_TX_ACTIVE
);

   // ------------------------------------------------------------------
   // types
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [DIV_W-1:0] cnt;
      logic             clk;
      logic             rise;
      logic             fall;
   } div_s;

   typedef struct packed {
      logic [PIN_W-1:0] sync1;
      logic [PIN_W-1:0] sync2;
      logic             armed;
      mode_e            mode;
      logic [1:0]       interp;
      logic             cfg_err;
      state_e           st;
      logic [7:0]       gap;
      div_s             txd;
      div_s             rxd;
      logic             rx_phase_b;
      logic [BUS_W-1:0] rx_b_hold;
      logic [BUS_W-1:0] tx_a;
      logic             tx_have_a;
      logic [BUS_W-1:0] tx_out_a;
      logic [BUS_W-1:0] tx_out_b;
      logic             tx_valid;
      logic [BUS_W-1:0] up_out;
      logic [BUS_W-1:0] up_oe_n;
      logic [BUS_W-1:0] lo_out;
      logic [BUS_W-1:0] lo_oe_n;
      logic             two_out;
      logic             two_oe_n;
      logic             three_out;
   } port_s;

   // ------------------------------------------------------------------
   // functions
   // ------------------------------------------------------------------
   // width strap decode
   function automatic mode_e decode_mode(input logic fd, input logic width,
                                         input logic compat);
      mode_e m;
      if (compat) begin
         m = MODE_COMPAT;
      end else if (fd) begin
         m = MODE_FULL_DUPLEX;
      end else if (width) begin
         m = MODE_HD_INTERLEAVE;
      end else begin
         m = MODE_HD_PARALLEL;
      end
      return m;
   endfunction

   function automatic logic interp_bad(input mode_e m, input logic [1:0] ip);
      logic bad;
      bad = (ip != INTERP_1X) && (ip != INTERP_2X) && (ip != INTERP_4X);
      if ((m != MODE_HD_PARALLEL) && (ip == INTERP_1X)) begin
         bad = 1'b1;
      end
      return bad;
   endfunction

   // a stopped divider finishes its high phase before resting low
   function automatic div_s step_div(input div_s d, input logic [DIV_W-1:0] half,
                                     input logic en);
      div_s s;
      s      = d;
      s.rise = 1'b0;
      s.fall = 1'b0;
      if (en || d.clk) begin
         if (d.cnt >= half - 1'b1) begin
            s.cnt  = '0;
            s.clk  = !d.clk;
            s.rise = !d.clk;
            s.fall = d.clk;
         end else begin
            s.cnt = d.cnt + 1'b1;
         end
      end else begin
         s.cnt = '0;
      end
      return s;
   endfunction

   // ------------------------------------------------------------------
   // receive fifo
   // ------------------------------------------------------------------
   logic [2*BUS_W-1:0] fifo_data;
   logic               fifo_valid;
   logic               fifo_pop;

   fdp_fifo #(
      .WIDTH (2 * BUS_W),
      .DEPTH (FIFO_DEPTH)
   ) u_rx_fifo (
      .i_clk       (I_MCLK),
      .i_rst       (I_SYS_RST),
      .i_in_data   ({I_RX_B_DATA, I_RX_A_DATA}),
      .i_in_valid  (I_RX_VALID),
      .o_in_ready  (O_RX_READY),
      .o_out_data  (fifo_data),
      .o_out_valid (fifo_valid),
      .i_out_ready (fifo_pop)
   );

   // ------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------
   port_s r;
   port_s next_r;

   logic [PIN_W-1:0] pins;
   assign pins = {I_IFACE_PIN_ONE, I_IFACE_PIN_TWO, I_FULL_DUPLEX_MODE,
                  I_COMPAT_MODE_SEL, I_INTERP_SEL, I_ADC_CLK_DIV,
                  I_RECEIVE_POWER_DOWN, I_TRANSMIT_POWER_DOWN,
                  I_UPPER_BUS, I_LOWER_BUS};

   always_comb begin
      logic             fd;
      logic             interleave_rx;
      logic             tx_on;
      logic             rx_on;
      logic             marker;
      logic [BUS_W-1:0] up_in;
      logic [BUS_W-1:0] lo_in;
      logic [DIV_W-1:0] rx_half;

      next_r          = r;
      next_r.sync1    = pins;
      next_r.sync2    = r.sync1;
      next_r.tx_valid = 1'b0;
      fifo_pop        = 1'b0;
      up_in           = r.sync2[P_UPPER +: BUS_W];
      lo_in           = r.sync2[P_LOWER +: BUS_W];
      fd              = (r.mode == MODE_FULL_DUPLEX);
      interleave_rx   = fd || (r.mode == MODE_HD_INTERLEAVE);
      // independent power down of each path
      tx_on = r.armed && !r.cfg_err && !r.sync2[P_TXPD] &&
              (r.st != ST_TURN) && (fd || r.st == ST_TX);
      rx_on = r.armed && !r.sync2[P_RXPD] &&
              (r.st != ST_TURN) && (fd || r.st == ST_RX);
      // adc clock divided down by the programmed ratio
      rx_half         = DIV_W'(RX_HALF_DIV << r.sync2[P_ADCDIV +: 2]);
      marker          = fd ? r.sync2[P_ONE] : lo_in[BUS_W-1];

      if (!r.armed) begin
         next_r.armed   = 1'b1;
         next_r.mode    = decode_mode(r.sync2[P_FD], r.sync2[P_WIDTH],
                                      r.sync2[P_COMPAT]);
         next_r.interp  = r.sync2[P_INTERP +: 2];
         next_r.cfg_err = interp_bad(next_r.mode, next_r.interp);
         next_r.st      = ST_TURN;
         next_r.gap     = '0;
      end

      // half duplex direction follows the selector
      case (r.st)
         ST_IDLE: begin
         end
         ST_RX: begin
            if (!fd && r.sync2[P_ONE]) begin
               next_r.st  = ST_TURN;
               next_r.gap = '0;
            end
         end
         ST_TX: begin
            if (!fd && !r.sync2[P_ONE]) begin
               next_r.st  = ST_TURN;
               next_r.gap = '0;
            end
         end
         ST_TURN: begin
            // buses idle and clocks low before turning
            if (!r.txd.clk && !r.rxd.clk) begin
               next_r.gap = r.gap + 1'b1;
               if (r.gap >= 8'(TURN_GAP_CYC - 1)) begin
                  next_r.st = (!fd && r.sync2[P_ONE]) ? ST_TX : ST_RX;
               end
            end
         end
         default: begin
            next_r.st = ST_IDLE;
         end
      endcase

      // tx clock gives one rising edge per interleaved word
      next_r.txd = step_div(r.txd, TX_HALF_DIV, tx_on);
      next_r.rxd = step_div(r.rxd, rx_half, rx_on);

      // ---------------- transmit capture ----------------
      // tx words arrive on the upper bus, except hd parallel B on the lower
      if (r.txd.fall && tx_on) begin
         if (r.mode == MODE_HD_PARALLEL) begin
            next_r.tx_out_a = up_in;
            next_r.tx_out_b = lo_in;
            next_r.tx_valid = 1'b1;
         end else if (marker) begin
            next_r.tx_a      = up_in;
            next_r.tx_have_a = 1'b1;
         end else begin
            // channel B word completes the pair
            next_r.tx_out_b  = up_in;
            next_r.tx_out_a  = r.tx_a;
            next_r.tx_valid  = r.tx_have_a;
            next_r.tx_have_a = 1'b0;
         end
      end
      if (!tx_on) begin
         next_r.tx_have_a = 1'b0;
      end

      // ---------------- receive drive ----------------
      if (next_r.rxd.fall && rx_on) begin
         if (interleave_rx) begin
            if (r.rx_phase_b) begin
               next_r.lo_out     = r.rx_b_hold;
               next_r.two_out    = 1'b1;
               next_r.rx_phase_b = 1'b0;
            end else if (fifo_valid) begin
               fifo_pop          = 1'b1;
               next_r.lo_out     = fifo_data[BUS_W-1:0];
               next_r.rx_b_hold  = fifo_data[2*BUS_W-1:BUS_W];
               next_r.two_out    = 1'b0;
               next_r.rx_phase_b = 1'b1;
            end
            // upper msb mirrors the rx channel marker
            next_r.up_out = {next_r.two_out, {(BUS_W-1){1'b0}}};
         end else if (fifo_valid) begin
            fifo_pop      = 1'b1;
            next_r.lo_out = fifo_data[BUS_W-1:0];
            next_r.up_out = fifo_data[2*BUS_W-1:BUS_W];
         end
      end
      if (!rx_on) begin
         next_r.rx_phase_b = 1'b0;
      end

      // ---------------- pin directions ----------------
      next_r.up_oe_n  = '1;
      next_r.lo_oe_n  = '1;
      next_r.two_oe_n = 1'b1;
      if (r.armed && r.st != ST_TURN && r.st != ST_IDLE) begin
         if (fd) begin
            next_r.lo_oe_n  = '0;
            next_r.two_oe_n = 1'b0;
         end else if (r.st == ST_RX) begin
            next_r.lo_oe_n = '0;
            if (r.mode == MODE_HD_INTERLEAVE) begin
               next_r.up_oe_n = {1'b0, {(BUS_W-1){1'b1}}};
            end else begin
               next_r.up_oe_n = '0;
            end
         end
      end

      // pin three carries the active path clock
      next_r.three_out = (fd || r.st == ST_TX || next_r.txd.clk) ? next_r.txd.clk : next_r.rxd.clk;
   end

   // ------------------------------------------------------------------
   // state register
   // ------------------------------------------------------------------
   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         r          <= '0;
         r.sync1    <= pins;
         r.sync2    <= r.sync1;
         r.mode     <= MODE_FULL_DUPLEX;
         r.st       <= ST_IDLE;
         r.up_oe_n  <= '1;
         r.lo_oe_n  <= '1;
         r.two_oe_n <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   // ------------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------------
   assign O_UPPER_BUS          = r.up_out;
   assign O_UPPER_BUS_OE_N     = r.up_oe_n;
   assign O_LOWER_BUS          = r.lo_out;
   assign O_LOWER_BUS_OE_N     = r.lo_oe_n;
   assign O_IFACE_PIN_TWO      = r.two_out;
   assign O_IFACE_PIN_TWO_OE_N = r.two_oe_n;
   assign O_IFACE_PIN_THREE    = r.three_out;
   assign O_TX_A_DATA          = r.tx_out_a;
   assign O_TX_B_DATA          = r.tx_out_b;
   assign O_TX_VALID           = r.tx_valid;
   assign O_MODE               = r.mode;
   assign O_INTERP             = r.interp;
   assign O_CFG_ERROR          = r.cfg_err;
   assign O_TX_ACTIVE          = (r.st == ST_TX) || (r.mode == MODE_FULL_DUPLEX && r.armed);

endmodule // flexible_converter_data_port

// File: tb/fdp_checker_assertions.sv
// concurrent checks on the converter data port pins
module fdp_checker
   import fdp_pkg::*;
#(
   parameter logic [DIV_W-1:0] TX_HALF_DIV = TX_HALF_DIV_DEF,
   parameter logic [DIV_W-1:0] RX_HALF_DIV = RX_HALF_DIV_DEF
) (
   input wire logic             I_MCLK,
   input wire logic             I_SYS_RST,
   input wire logic             O_IFACE_PIN_TWO_OE_N,
   input wire logic             O_IFACE_PIN_THREE,
   input wire logic [BUS_W-1:0] O_UPPER_BUS_OE_N,
   input wire logic [BUS_W-1:0] O_LOWER_BUS_OE_N,
   input wire logic             O_TX_VALID,
   input wire logic [1:0]       O_MODE,
   input wire logic [1:0]       O_INTERP,
   input wire logic             O_CFG_ERROR,
   input wire logic             O_TX_ACTIVE
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam int TXH1 = int'(TX_HALF_DIV) - 1;
   default clocking cb @(posedge I_MCLK); endclocking
   default disable iff (I_SYS_RST);

   property p_reset_quiet;
      @(posedge I_MCLK) disable iff (1'b0)
      $past(I_SYS_RST) |-> &O_UPPER_BUS_OE_N && &O_LOWER_BUS_OE_N && O_IFACE_PIN_TWO_OE_N
         && !O_TX_VALID && !O_IFACE_PIN_THREE;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("pins active in reset");
   property p_fd_tx_clock;
      $rose(O_IFACE_PIN_THREE) && O_MODE == MODE_FULL_DUPLEX
         |-> ##TXH1 O_IFACE_PIN_THREE ##1 !O_IFACE_PIN_THREE;
   endproperty
   a_fd_tx_clock: assert property (p_fd_tx_clock) else $error("tx clock high phase");
   property p_pin_two_hd;
      O_MODE != MODE_FULL_DUPLEX |-> O_IFACE_PIN_TWO_OE_N;
   endproperty
   a_pin_two_hd: assert property (p_pin_two_hd) else $error("pin two driven");
   property p_upper_tx;
      O_TX_ACTIVE |-> &O_UPPER_BUS_OE_N;
   endproperty
   a_upper_tx: assert property (p_upper_tx) else $error("upper driven in tx");
   property p_lower_hd_tx;
      O_TX_ACTIVE && O_MODE != MODE_FULL_DUPLEX |-> &O_LOWER_BUS_OE_N;
   endproperty
   a_lower_hd_tx: assert property (p_lower_hd_tx) else $error("lower driven in tx");
   property p_half_duplex_interleaved_mode_marker;
      O_MODE == MODE_HD_INTERLEAVE && !O_UPPER_BUS_OE_N[BUS_W-1]
         |-> &O_UPPER_BUS_OE_N[BUS_W-2:0];
   endproperty
   a_half_duplex_interleaved_mode_marker: assert property (p_half_duplex_interleaved_mode_marker) else $error("idle bus bits driven");
   property p_cfg_rule;
      !$past(I_SYS_RST) |-> O_CFG_ERROR == ((O_INTERP == INTERP_1X
         && O_MODE != MODE_HD_PARALLEL) || O_INTERP == 2'h3);
   endproperty
   a_cfg_rule: assert property (p_cfg_rule) else $error("config error flag");
   property p_cfg_no_tx;
      O_CFG_ERROR |-> !O_TX_VALID;
   endproperty
   a_cfg_no_tx: assert property (p_cfg_no_tx) else $error("tx in bad config");
   property p_valid_gap;
      O_TX_VALID |=> !O_TX_VALID [*3];
   endproperty
   a_valid_gap: assert property (p_valid_gap) else $error("tx pairs too close");
   property p_mode_hold;
      !$past(I_SYS_RST) && !$past(I_SYS_RST, 2) |-> $stable(O_MODE) && $stable(O_INTERP);
   endproperty
   a_mode_hold: assert property (p_mode_hold) else $error("mode changed");
endmodule // fdp_checker

bind flexible_converter_data_port fdp_checker #(
   .TX_HALF_DIV(TX_HALF_DIV),
   .RX_HALF_DIV(RX_HALF_DIV)
) fdp_checker_inst (
   .I_MCLK(I_MCLK),
   .I_SYS_RST(I_SYS_RST),
   .O_IFACE_PIN_TWO_OE_N(O_IFACE_PIN_TWO_OE_N),
   .O_IFACE_PIN_THREE(O_IFACE_PIN_THREE),
   .O_UPPER_BUS_OE_N(O_UPPER_BUS_OE_N),
   .O_LOWER_BUS_OE_N(O_LOWER_BUS_OE_N),
   .O_TX_VALID(O_TX_VALID),
   .O_MODE(O_MODE),
   .O_INTERP(O_INTERP),
   .O_CFG_ERROR(O_CFG_ERROR),
   .O_TX_ACTIVE(O_TX_ACTIVE)
);

// File: tb/host_model.sv
// baseband host model: sends a counting tx stream on the link clock
module host_model
   import fdp_pkg::*;
(
   input  wire logic             i_clk,
   input  wire logic             i_rst,
   input  wire logic [BUS_W-1:0] i_base,
   input  wire logic             i_link_clk,
   input  wire logic [1:0]       i_mode,
   input  wire logic             i_tx_active,
   output logic      [BUS_W-1:0] o_upper,
   output logic      [BUS_W-1:0] o_lower,
   output logic                  o_marker
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [BUS_W-1:0] k = '0;
   logic             slot_b = 1'b0;
   logic             par;

   // ---------------------------------------------------------------
   // word source: pair is k then ~k
   // ---------------------------------------------------------------
   assign par = (i_mode == MODE_HD_PARALLEL);
   assign o_marker = !slot_b;
   // parallel A/B split, interleaved marker on lower msb
   always_comb begin
      o_upper = ((par || !slot_b) ? k : ~k) ^ {BUS_W{!i_tx_active}};
      o_lower = (par ? ~k : {o_marker, ~k[BUS_W-2:0]}) ^ {BUS_W{!i_tx_active}};
   end
   always @(posedge i_clk) if (i_rst) begin
      k <= i_base;
      slot_b <= 1'b0;
   end
   // one word per link clock period, one A/B word pair in parallel mode
   always @(negedge i_link_clk) begin
      #2;
      if (i_tx_active === 1'b1 && !i_rst) begin
         if (par || slot_b) k = k + 1'b1;
         slot_b = !par && !slot_b;
      end
   end
endmodule // host_model

// File: tb/testbench.sv
// self-checking bench for the converter data port
module testbench
   import fdp_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic I_MCLK = 1'b0, I_SYS_RST = 1'b1, sel = 1'b1, strap = 1'b1, I_RX_VALID = 1'b0;
   logic I_FULL_DUPLEX_MODE = 1'b1, I_COMPAT_MODE_SEL = 1'b0, I_TRANSMIT_POWER_DOWN = 1'b0;
   logic I_RECEIVE_POWER_DOWN = 1'b1, ind, par, last_ind, last_p3, h_marker;
   logic [1:0] I_INTERP_SEL = INTERP_2X, I_ADC_CLK_DIV = 2'h0, O_MODE, O_INTERP;
   logic [BUS_W-1:0] I_RX_A_DATA = '0, I_RX_B_DATA = '0, base = '0, exp_k, last_low;
   logic [BUS_W-1:0] O_UPPER_BUS, O_UPPER_BUS_OE_N, O_LOWER_BUS, O_LOWER_BUS_OE_N;
   logic [BUS_W-1:0] O_TX_A_DATA, O_TX_B_DATA, h_up, h_low, qa[$], qb[$];
   logic O_IFACE_PIN_TWO, O_IFACE_PIN_TWO_OE_N, O_IFACE_PIN_THREE, O_RX_READY;
   logic O_TX_VALID, O_CFG_ERROR, O_TX_ACTIVE;
   int   mismatches = 0, compares = 0, seed = 94, tx_n = 0;
   wire logic [BUS_W-1:0] up_w = (O_UPPER_BUS & ~O_UPPER_BUS_OE_N) | (h_up & O_UPPER_BUS_OE_N);
   wire logic [BUS_W-1:0] lo_w = (O_LOWER_BUS & ~O_LOWER_BUS_OE_N) | (h_low & O_LOWER_BUS_OE_N);
   wire logic pin_one = (O_MODE == MODE_FULL_DUPLEX) ? h_marker : sel;
   wire logic pin_two = O_IFACE_PIN_TWO_OE_N ? strap : O_IFACE_PIN_TWO;

   always #12.5 I_MCLK = ~I_MCLK;

   flexible_converter_data_port flexible_converter_data_port_inst (
      .I_MCLK(I_MCLK), .I_SYS_RST(I_SYS_RST), .I_IFACE_PIN_ONE(pin_one),
      .I_IFACE_PIN_TWO(pin_two), .O_IFACE_PIN_TWO(O_IFACE_PIN_TWO),
      .O_IFACE_PIN_TWO_OE_N(O_IFACE_PIN_TWO_OE_N), .O_IFACE_PIN_THREE(O_IFACE_PIN_THREE),
      .I_UPPER_BUS(up_w), .O_UPPER_BUS(O_UPPER_BUS), .O_UPPER_BUS_OE_N(O_UPPER_BUS_OE_N),
      .I_LOWER_BUS(lo_w), .O_LOWER_BUS(O_LOWER_BUS), .O_LOWER_BUS_OE_N(O_LOWER_BUS_OE_N),
      .I_FULL_DUPLEX_MODE(I_FULL_DUPLEX_MODE), .I_COMPAT_MODE_SEL(I_COMPAT_MODE_SEL),
      .I_INTERP_SEL(I_INTERP_SEL), .I_ADC_CLK_DIV(I_ADC_CLK_DIV),
      .I_RECEIVE_POWER_DOWN(I_RECEIVE_POWER_DOWN), .I_TRANSMIT_POWER_DOWN(I_TRANSMIT_POWER_DOWN),
      .I_RX_A_DATA(I_RX_A_DATA), .I_RX_B_DATA(I_RX_B_DATA), .I_RX_VALID(I_RX_VALID),
      .O_RX_READY(O_RX_READY), .O_TX_A_DATA(O_TX_A_DATA), .O_TX_B_DATA(O_TX_B_DATA),
      .O_TX_VALID(O_TX_VALID), .O_MODE(O_MODE), .O_INTERP(O_INTERP),
      .O_CFG_ERROR(O_CFG_ERROR), .O_TX_ACTIVE(O_TX_ACTIVE)
   );
   host_model host_model_inst (
      .i_clk(I_MCLK), .i_rst(I_SYS_RST), .i_base(base), .i_link_clk(O_IFACE_PIN_THREE),
      .i_mode(O_MODE), .i_tx_active(O_TX_ACTIVE), .o_upper(h_up), .o_lower(h_low),
      .o_marker(h_marker)
   );

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task step(input int n);
      repeat (n) @(posedge I_MCLK);
      #2;
   endtask
   task chk(input string what, input logic [BUS_W-1:0] exp, input logic [BUS_W-1:0] got);
      compares++;
      if (got !== exp) begin
         $display("ERROR %s expected %h seen %h", what, exp, got);
         mismatches++;
      end
   endtask
   task summarize();
      if (mismatches == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task cfg(input logic fd, compat, width, input logic [1:0] interp, mode);
      int v;
      I_SYS_RST = 1'b1;
      I_FULL_DUPLEX_MODE = fd;
      I_COMPAT_MODE_SEL = compat;
      strap = width;
      I_INTERP_SEL = interp;
      sel = 1'b1;
      v = $random(seed);
      base = v[BUS_W-1:0];
      I_ADC_CLK_DIV = v[BUS_W+1:BUS_W];
      step(12);
      I_SYS_RST = 1'b0;
      exp_k = base;
      tx_n = 0;
      step(3);
      chk("mode", {8'h00, mode}, {8'h00, O_MODE});
   endtask
   task push(input int n);
      int v;
      logic ok;
      for (int i = 0; i < n; i++) begin
         v = $random(seed);
         I_RX_A_DATA = v[BUS_W-1:0];
         I_RX_B_DATA = v[2*BUS_W-1:BUS_W];
         I_RX_VALID = 1'b1;
         @(negedge I_MCLK);
         ok = (O_RX_READY === 1'b1);
         step(1);
         if (!ok) break;
         qa.push_back(I_RX_A_DATA);
         qb.push_back(I_RX_B_DATA);
      end
      I_RX_VALID = 1'b0;
   endtask
   task drain();
      for (int t = 0; t < 4000 && qa.size() > 0; t++) step(1);
      chk("rx pending", '0, BUS_W'(qa.size()));
   endtask

   // ---------------------------------------------------------------
   // result monitors
   // ---------------------------------------------------------------
   always @(posedge I_MCLK) begin
      #1;
      if (O_TX_VALID === 1'b1) begin
         chk("tx a", exp_k, O_TX_A_DATA);
         chk("tx b", ~exp_k, O_TX_B_DATA);
         exp_k++;
         tx_n++;
      end
      ind = (O_MODE === MODE_FULL_DUPLEX) ? O_IFACE_PIN_TWO : O_UPPER_BUS[BUS_W-1];
      par = (O_MODE === MODE_HD_PARALLEL) || (O_MODE === MODE_COMPAT);
      if (!I_SYS_RST && O_LOWER_BUS_OE_N === '0 && qa.size() > 0) begin
         if (par && last_p3 === 1'b1 && O_IFACE_PIN_THREE === 1'b0) begin
            chk("rx lower", qa.pop_front(), O_LOWER_BUS);
            chk("rx upper", qb.pop_front(), O_UPPER_BUS);
         end else if (!par && last_ind === 1'b0 && ind === 1'b1) begin
            chk("rx first", qa.pop_front(), last_low);
            chk("rx second", qb.pop_front(), O_LOWER_BUS);
         end
      end
      last_ind = ind;
      last_p3 = O_IFACE_PIN_THREE;
      last_low = O_LOWER_BUS;
   end

   initial begin
      #750000;
      mismatches++;
      summarize();
   end

   initial begin
      cfg(1'b1, 1'b0, 1'b1, INTERP_2X, MODE_FULL_DUPLEX);
      push(6);
      step(80);
      chk("rx held", 10'h006, BUS_W'(qa.size()));
      chk("tx while rx down", 10'h001, BUS_W'(tx_n > 2));
      I_RECEIVE_POWER_DOWN = 1'b0;
      drain();
      cfg(1'b1, 1'b0, 1'b1, INTERP_1X, MODE_FULL_DUPLEX);
      step(100);
      chk("cfg error", 10'h001, {9'h000, O_CFG_ERROR});
      chk("tx refused", '0, BUS_W'(tx_n));
      cfg(1'b0, 1'b0, 1'b1, INTERP_4X, MODE_HD_INTERLEAVE);
      push(40);
      step(20);
      chk("fifo fill", BUS_W'(FIFO_DEPTH), BUS_W'(qa.size()));
      chk("half_duplex_interleaved_mode tx", 10'h001, BUS_W'(tx_n > 2));
      sel = 1'b0;
      drain();
      cfg(1'b0, 1'b0, 1'b0, INTERP_1X, MODE_HD_PARALLEL);
      chk("cfg error", '0, {9'h000, O_CFG_ERROR});
      push(5);
      step(60);
      chk("half_duplex_parallel_mode tx", 10'h001, BUS_W'(tx_n > 2));
      sel = 1'b0;
      drain();
      cfg(1'b0, 1'b1, 1'b1, INTERP_2X, MODE_COMPAT);
      push(5);
      step(60);
      chk("compat tx", 10'h001, BUS_W'(tx_n > 2));
      sel = 1'b0;
      drain();
      summarize();
   end
endmodule // testbench
